//--- logic/bus_state_status.v
// Status reporting part of the two-wire bus controller: status byte and service request flag.
// Assumes the byte engine pulses state_enter with a code, and software sees I/O reads/writes.
`include "bus_state_regs.vh"
// Notes on behaviour
// - The status byte carries the five-bit state code in bits 7:3 and reads zero in bits 2:0.
// - Reads at address 00CCh return the status byte while writes there load the clock divider.
// - Twenty-nine code values exist, idle plus twenty-eight defined controller states.
// - While the idle code stands no interrupt is raised and the flag stays clear.
// - Entering a defined state loads its code and sets the service request flag.
// - Clearing the service request flag returns the status byte to F8h.
// - Each state's byte value is its code times eight, bus error being 00h.
// - An illegal bus condition enters bus error; stop plus flag clear returns to idle silently.
// - A flag value of one means set and zero means not set.
module bus_state_status (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Processor I/O access
	input wire [15:0] io_addr,
	input wire io_rd,
	input wire io_wr,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	output wire io_rd_hit,
	// Byte engine side
	input wire state_enter,
	input wire [4:0] state_code,
	input wire bus_illegal,
	// Control register side
	input wire flag_clear,
	input wire stop_request_bit,
	output wire service_request_flag,
	output wire irq,
	output wire stop_suppress,
	// Clock divider register contents
	output wire [7:0] clock_divider_register
);
	reg [4:0] code_r;
	reg [4:0] code_nxt;
	reg flag_r;
	reg flag_nxt;
	reg [7:0] div_r;
	reg stop_sup_r;
	wire enter_ok;
	wire sel;

	status_code_check u_check (
		.code(state_code),
		.defined(enter_ok)
	);

	assign sel = (io_addr == `STATUS_ADDR);
	assign io_rd_hit = sel & io_rd;

	function [7:0] status_byte;
		input [4:0] c;
		begin
			status_byte = {c, 3'b000};
		end
	endfunction

	always @* begin
		code_nxt = code_r;
		flag_nxt = flag_r;
		if (flag_clear) begin
			code_nxt = `CODE_IDLE;
			flag_nxt = 1'b0;
		end
		// A state entered in the cycle of the clear wins over the clear.
		if (bus_illegal) begin
			code_nxt = `CODE_BUS_ERROR;
			flag_nxt = 1'b1;
		end else if (state_enter && enter_ok) begin
			code_nxt = state_code;
			flag_nxt = 1'b1;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			code_r <= `CODE_IDLE;
			flag_r <= 1'b0;
			div_r <= `DIVIDER_RESET;
			stop_sup_r <= 1'b0;
			io_rdata <= 8'h00;
		end else begin
			code_r <= code_nxt;
			flag_r <= flag_nxt;
			if (sel && io_wr) begin
				div_r <= {1'b0, io_wdata[`DIVIDER_RSVD_BIT-1:0]};
			end
			// Leaving bus error via stop and flag clear must not drive a stop on the bus.
			if (flag_clear && stop_request_bit && code_r == `CODE_BUS_ERROR) begin
				stop_sup_r <= 1'b1;
			end else if (state_enter || bus_illegal) begin
				stop_sup_r <= 1'b0;
			end
			if (sel && io_rd) begin
				io_rdata <= status_byte(code_r);
			end
		end
	end

	assign service_request_flag = flag_r;
	assign irq = flag_r & (code_r != `CODE_IDLE);
	assign stop_suppress = stop_sup_r;
	assign clock_divider_register = div_r;
endmodule

//--- logic/bus_state_regs.vh
// Register offsets, field positions, reset values and status codes of the bus state reporter.
// Assumes an 8-bit processor I/O space with 16-bit addresses.
`ifndef BUS_STATE_REGS_VH
`define BUS_STATE_REGS_VH
`define STATUS_ADDR 16'h00CC
`define STATUS_RESET 8'hF8
`define STATUS_CODE_HI 7
`define STATUS_CODE_LO 3
`define CODE_IDLE 5'h1F
`define CODE_BUS_ERROR 5'h00
`define CODE_NUM_DEFINED 6'h1C
`define CODE_LAST_DEFINED 5'h1B
`define DIVIDER_RESET 8'h00
`define DIVIDER_RSVD_BIT 7
`endif

//--- logic/status_code_check.v
// Classifies a 5-bit state code as one of the defined controller states.
// Assumes codes are state numbers, the status byte holding the code times eight.
`include "bus_state_regs.vh"
module status_code_check (
	// Code under test
	input wire [4:0] code,
	// Result
	output wire defined
);
	// Codes 00h to 1Bh (bytes 00h to D8h) are defined; 1Fh is idle; others do not exist.
	assign defined = (code <= `CODE_LAST_DEFINED);
endmodule

//--- tb/engine_model.sv
// Engine stand-in turning bench requests into one-cycle pulses.
// Code lines toggle while idle so a stale code is never seen.
module engine_model(input wire logic clk_sys,input wire logic [6:0] req,
	output logic state_enter=0,bus_illegal=0,output logic [4:0] state_code=0);
	always @(posedge clk_sys) begin
		{state_enter,bus_illegal}<=req[6:5];
		state_code<=req[6]?req[4:0]:~state_code;
	end
endmodule

//--- tb/bus_state_status_monitor.sv
// Status checker.
// Bound to the status block below.
module bus_state_status_monitor(input wire logic clk_sys,rst_n,io_rd_hit,state_enter,flag_clear,
	bus_illegal,service_request_flag,irq,input wire logic [4:0] state_code,
	input wire logic [7:0] io_rdata);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_enter; state_enter&&!bus_illegal&&state_code<5'h1C ##1 io_rd_hit; endsequence
	a_low_zero: assert property (io_rdata[2:0]==3'h0) else $error("low");
	a_irq_flag: assert property (irq==service_request_flag) else $error("irq");
	a_code_read:
		assert property (s_enter |=> io_rdata=={$past(state_code,2),3'h0}) else $error("code");
	sequence s_illegal; bus_illegal ##1 io_rd_hit; endsequence
	a_illegal_err:
		assert property (s_illegal |=> io_rdata==8'h00) else $error("bus error code");
	a_enter_flag:
		assert property (state_enter&&state_code<5'h1C |=> service_request_flag) else $error("set");
	a_clear_flag:
		assert property (flag_clear&&!state_enter&&!bus_illegal |=> !service_request_flag)
		else $error("clear");
	a_idle_read:
		assert property (io_rd_hit&&!service_request_flag |=> io_rdata==8'hF8) else $error("idle");
endmodule
bind bus_state_status bus_state_status_monitor mon(.*);

//--- tb/bus_state_status_tb.sv
// Status block bench.
// Uses engine_model and the bound checker.
module bus_state_status_tb;
	timeunit 1ns; timeprecision 1ns;
	logic clk_sys=0,rst_n=0,io_rd=0,io_wr=0,flag_clear=0,stop_request_bit=0;
	logic [15:0] io_addr=16'h00CC; logic [7:0] io_wdata=8'hFF,io_rdata,clock_divider_register;
	logic [6:0] req=0; logic [4:0] state_code; int fails=0,checked=0,k;
	wire io_rd_hit,service_request_flag,irq,stop_suppress,state_enter,bus_illegal;
	bus_state_status uut(.*);
	engine_model eng(.*);
	always #10 clk_sys=~clk_sys;
	task cmp(string n,logic [7:0] e,a); checked++;
		if (a!==e) begin fails++; $display("[FAIL] %s exp %h got %h",n,e,a); end endtask
	task st(logic [6:0] v,logic c,w,logic [7:0] e);
		@(posedge clk_sys) {req,flag_clear}<={v,c};
		@(posedge clk_sys) {req,flag_clear}<=0;
		@(posedge clk_sys) {io_rd,io_wr}<={!w,w};
		@(posedge clk_sys) {io_rd,io_wr}<=0;
		#1 cmp("rdata",e,io_rdata); endtask
	task complete_run; $display("checked %0d fails %0d",checked,fails);
		if (fails==0&&checked>0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish; endtask
	initial begin #20us fails++; complete_run; end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n<=1;
		st(0,0,0,8'hF8);
		cmp("flag",8'h00,{7'h0,service_request_flag});
		$display("reset test end");
		for (k=0;k<32;k++) begin
			st({2'b10,k[4:0]},0,0,k<28?{k[4:0],3'h0}:8'hF8);
			cmp("flag",{7'h0,k<28},{7'h0,service_request_flag});
			cmp("irq",{7'h0,k<28},{7'h0,irq});
			st(0,1,0,8'hF8);
			cmp("irq",8'h00,{7'h0,irq});
		end
		$display("code test end");
		st(7'h20,0,1,8'hF8);
		cmp("divider",8'h7F,clock_divider_register);
		st(0,0,0,8'h00);
		@(posedge clk_sys) stop_request_bit<=1;
		st(0,1,0,8'hF8);
		cmp("suppress",8'h01,{7'h0,stop_suppress});
		cmp("flag",8'h00,{7'h0,service_request_flag});
		$display("bus error test end");
		$display("tests end");
		complete_run;
	end
endmodule
